// ### verilog/sdp_pkg.sv
/*
 * Shared constants and types of the shape drawing parameter registers.
 * Assumes a 32-bit APB slave whose word index equals the register index.
 */
`default_nettype none

package sdp_pkg;
    localparam int SDP_CW = 13;
    localparam int SDP_NCOORD = 10;
    localparam int SDP_ADDR_W = 12;
    localparam int SDP_ADDR_LSB = 2;
    localparam int SDP_HI_BITS = 5;

    localparam logic [7:0] SDP_IDX_DEPTH = 8'h10;
    localparam logic [7:0] SDP_IDX_LINE_CTRL = 8'h67;
    localparam logic [7:0] SDP_IDX_CURVE_CTRL = 8'h76;
    localparam logic [7:0] SDP_IDX_RED = 8'hD2;
    localparam logic [7:0] SDP_IDX_GREEN = 8'hD3;
    localparam logic [7:0] SDP_IDX_BLUE = 8'hD4;
    localparam logic [7:0] SDP_COORD_LO [SDP_NCOORD] = '{8'h68, 8'h6A, 8'h6C, 8'h6E, 8'h70,
                                                         8'h72, 8'h77, 8'h79, 8'h7B, 8'h7D};

    localparam int SDP_SLOT_EP1X = 0;
    localparam int SDP_SLOT_EP1Y = 1;
    localparam int SDP_SLOT_EP2X = 2;
    localparam int SDP_SLOT_EP2Y = 3;
    localparam int SDP_SLOT_V3X = 4;
    localparam int SDP_SLOT_V3Y = 5;
    localparam int SDP_SLOT_MAJR = 6;
    localparam int SDP_SLOT_MINR = 7;
    localparam int SDP_SLOT_CX = 8;
    localparam int SDP_SLOT_CY = 9;

    localparam int SDP_START_BIT = 7;
    localparam int SDP_CURVE_FILL_BIT = 6;
    localparam int SDP_LINE_FILL_BIT = 5;
    localparam int SDP_SHAPE_MSB = 5;
    localparam int SDP_SHAPE_LSB = 4;
    localparam int SDP_PRIM_MSB = 4;
    localparam int SDP_PRIM_LSB = 1;
    localparam int SDP_QUAD_MSB = 1;
    localparam int SDP_QUAD_LSB = 0;

    localparam logic [7:0] SDP_COLOUR_RST = 8'hFF;
    localparam logic [3:0] SDP_PRIM_LINE = 4'h0;

    localparam logic [3:0] SDP_RED_KEEP [3] = '{4'h3, 4'h5, 4'h8};
    localparam logic [3:0] SDP_GREEN_KEEP [3] = '{4'h3, 4'h6, 4'h8};
    localparam logic [3:0] SDP_BLUE_KEEP [3] = '{4'h2, 4'h5, 4'h8};

    typedef enum logic [1:0] {
        SDP_DEPTH_256 = 2'h0,
        SDP_DEPTH_65K = 2'h1,
        SDP_DEPTH_16M = 2'h2
    } sdp_depth_t;

    typedef enum logic [1:0] {
        SDP_SHAPE_ELLIPSE = 2'h0,
        SDP_SHAPE_ARC = 2'h1,
        SDP_SHAPE_RECT = 2'h2,
        SDP_SHAPE_RRECT = 2'h3
    } sdp_shape_t;

    typedef enum logic [1:0] {
        SDP_QUAD_BL = 2'h0,
        SDP_QUAD_UL = 2'h1,
        SDP_QUAD_UR = 2'h2,
        SDP_QUAD_BR = 2'h3
    } sdp_quad_t;
endpackage

`default_nettype wire

// ### verilog/sdp_coord_bank.sv
/*
 * Bank of 13-bit pixel values, each written as a low byte and a five-bit high byte.
 * Assumes the caller decodes the byte index into a slot and a high/low select.
 */
`timescale 1ns/10ps
`default_nettype none

module sdp_coord_bank
    import sdp_pkg::*;
#(
    parameter int N = sdp_pkg::SDP_NCOORD
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_slot,
    input wire logic wr_hi,
    input wire logic [7:0] wr_byte,
    output logic [sdp_pkg::SDP_CW-1:0] coord_q [N]
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < N; i++)
            begin
                coord_q[i] <= '0;
            end
        end
        else if (wr_en && int'(wr_slot) < N)
        begin
            // High byte keeps bits 4:0 only; bits 7:5 are dropped.
            if (wr_hi)
            begin
                coord_q[wr_slot][SDP_CW-1:8] <= wr_byte[SDP_HI_BITS-1:0];
            end
            else
            begin
                coord_q[wr_slot][7:0] <= wr_byte;
            end
        end
    end

    hi_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && wr_hi && int'(wr_slot) < N) |=> coord_q[$past(wr_slot)][SDP_CW-1:8] == $past(wr_byte[4:0]))
        else $error("High byte write did not land in bits 12:8.");
endmodule

`default_nettype wire

// ### verilog/sdp_draw_ctl.sv
/*
 * Start and busy flag of one drawing engine.
 * Assumes done is a one-cycle pulse from the rasteriser on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module sdp_draw_ctl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic wr_start,
    input wire logic done,
    output logic busy_q,
    output logic start_q,
    output logic stop_q
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
        end
        else if (wr_en)
        begin
            // A start written in the cycle of done wins over the clear.
            busy_q <= wr_start;
        end
        else if (done)
        begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else
        begin
            start_q <= wr_en && wr_start;
            stop_q <= wr_en && !wr_start && busy_q;
        end
    end

    start_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && wr_start) |=> (busy_q && start_q))
        else $error("Start write did not raise busy and start.");

    done_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy_q && done && !wr_en) |=> !busy_q)
        else $error("Busy did not fall after done.");
endmodule

`default_nettype wire

// ### verilog/sdp_regs.sv
/*
 * APB register bank of the shape drawing engine parameters and control.
 * Assumes an APB master on pclk and a rasteriser that pulses done signals on pclk.
 */
// Summary of operation
// - Endpoint-1 Y is 13 bits: low byte 6Ah, bits 4:0 of 6Bh.
// - Endpoint-2 X is 13 bits: low byte 6Ch, bits 4:0 of 6Dh.
// - Endpoint-2 Y is 13 bits: low byte 6Eh, bits 4:0 of 6Fh.
// - Vertex-3 X is 13 bits: low byte 70h, bits 4:0 of 71h.
// - Vertex-3 Y is 13 bits: low byte 72h, bits 4:0 of 73h.
// - Triangle with two equal vertices draws a line, three equal a dot.
// - Curve control bit 7 starts or stops; reads one while drawing.
// - Curve control bit 6 selects filled or outline shape.
// - Curve control bits 5:4 pick ellipse, arc, rectangle or rounded rectangle.
// - Curve control bits 1:0 pick the arc quadrant.
// - Major radius is 13 bits: low byte 77h, bits 4:0 of 78h.
// - Minor radius is 13 bits: low byte 79h, bits 4:0 of 7Ah.
// - Centre X is 13 bits: low byte 7Bh, bits 4:0 of 7Ch.
// - Centre Y is 13 bits: low byte 7Dh, bits 4:0 of 7Eh.
// - Radius and centre values count whole pixels.
// - Red resets to FFh; keeps 3, 5 or 8 top bits per depth.
// - Green resets to FFh; keeps 3, 6 or 8 top bits per depth.
// - Endpoint-1 X is 13 bits: low byte 68h, bits 4:0 of 69h.
// - Line control bit 7 starts or stops; reads one while drawing.
// - Blue resets to FFh; keeps 2, 5 or 8 top bits per depth.
`timescale 1ns/10ps
`default_nettype none

module sdp_regs
    import sdp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sdp_pkg::SDP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire logic line_done,
    input wire logic curve_done,
    output logic line_start_q,
    output logic line_stop_q,
    output logic line_busy_q,
    output logic [3:0] line_prim_q,
    output logic line_fill_q,
    output logic curve_start_q,
    output logic curve_stop_q,
    output logic curve_busy_q,
    output logic curve_fill_q,
    output sdp_pkg::sdp_shape_t curve_shape_q,
    output sdp_pkg::sdp_quad_t curve_quad_q,
    output logic [sdp_pkg::SDP_CW-1:0] endpoint1_x,
    output logic [sdp_pkg::SDP_CW-1:0] endpoint1_y,
    output logic [sdp_pkg::SDP_CW-1:0] endpoint2_x,
    output logic [sdp_pkg::SDP_CW-1:0] endpoint2_y,
    output logic [sdp_pkg::SDP_CW-1:0] vertex3_x,
    output logic [sdp_pkg::SDP_CW-1:0] vertex3_y,
    output logic [sdp_pkg::SDP_CW-1:0] major_radius,
    output logic [sdp_pkg::SDP_CW-1:0] minor_radius,
    output logic [sdp_pkg::SDP_CW-1:0] centre_x,
    output logic [sdp_pkg::SDP_CW-1:0] centre_y,
    output logic tri_as_line_q,
    output logic tri_as_dot_q,
    output logic [7:0] fg_red_q,
    output logic [7:0] fg_green_q,
    output logic [7:0] fg_blue_q
);
    import sdp_pkg::*;

    logic [7:0] idx;
    logic access;
    logic wr_now;
    logic [7:0] wbyte;
    logic coord_hit;
    logic coord_hi;
    logic [3:0] coord_slot;
    logic line_wr;
    logic curve_wr;
    logic [SDP_CW-1:0] coord_q [SDP_NCOORD];
    logic [7:0] red_q;
    logic [7:0] green_q;
    logic [7:0] blue_q;
    sdp_depth_t depth_q;
    logic [7:0] rd_d;
    logic hit_d;

    // Finds the coordinate slot and byte half for a register index.
    function automatic logic [5:0] coord_decode(input logic [7:0] i);
        logic [5:0] r;
        r = '0;
        for (int s = 0; s < SDP_NCOORD; s++)
        begin
            if (i == SDP_COORD_LO[s])
            begin
                r = {1'b1, 1'b0, 4'(s)};
            end
            if (i == SDP_COORD_LO[s] + 8'h01)
            begin
                r = {1'b1, 1'b1, 4'(s)};
            end
        end
        return r;
    endfunction

    // Keeps the top n bits of a colour byte and clears the rest.
    function automatic logic [7:0] keep_top(input logic [7:0] c, input logic [3:0] n);
        logic [7:0] m;
        m = 8'hFF << (4'h8 - n);
        return c & m;
    endfunction

    function automatic int depth_sel(input sdp_depth_t d);
        int r;
        r = 2;
        if (d == SDP_DEPTH_256)
        begin
            r = 0;
        end
        else if (d == SDP_DEPTH_65K)
        begin
            r = 1;
        end
        return r;
    endfunction

    assign idx = paddr[SDP_ADDR_LSB+7:SDP_ADDR_LSB];
    assign access = psel && penable;
    assign wr_now = access && pready_q && pwrite && pstrb[0];
    assign wbyte = pwdata[7:0];
    assign {coord_hit, coord_hi, coord_slot} = coord_decode(idx);
    assign line_wr = wr_now && idx == SDP_IDX_LINE_CTRL;
    assign curve_wr = wr_now && idx == SDP_IDX_CURVE_CTRL;

    assign endpoint1_x = coord_q[SDP_SLOT_EP1X];
    assign endpoint1_y = coord_q[SDP_SLOT_EP1Y];
    assign endpoint2_x = coord_q[SDP_SLOT_EP2X];
    assign endpoint2_y = coord_q[SDP_SLOT_EP2Y];
    assign vertex3_x = coord_q[SDP_SLOT_V3X];
    assign vertex3_y = coord_q[SDP_SLOT_V3Y];
    assign major_radius = coord_q[SDP_SLOT_MAJR];
    assign minor_radius = coord_q[SDP_SLOT_MINR];
    assign centre_x = coord_q[SDP_SLOT_CX];
    assign centre_y = coord_q[SDP_SLOT_CY];

    sdp_coord_bank #(
        .N(SDP_NCOORD)
    ) u_coord (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_now && coord_hit),
        .wr_slot(coord_slot),
        .wr_hi(coord_hi),
        .wr_byte(wbyte),
        .coord_q(coord_q)
    );

    sdp_draw_ctl u_line (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(line_wr),
        .wr_start(wbyte[SDP_START_BIT]),
        .done(line_done),
        .busy_q(line_busy_q),
        .start_q(line_start_q),
        .stop_q(line_stop_q)
    );

    sdp_draw_ctl u_curve (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(curve_wr),
        .wr_start(wbyte[SDP_START_BIT]),
        .done(curve_done),
        .busy_q(curve_busy_q),
        .start_q(curve_start_q),
        .stop_q(curve_stop_q)
    );

    // The access phase lasts two cycles; pready stands for one.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
        end
        else
        begin
            pready_q <= access && !pready_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_prim_q <= SDP_PRIM_LINE;
            line_fill_q <= 1'b0;
        end
        else if (line_wr)
        begin
            line_prim_q <= wbyte[SDP_PRIM_MSB:SDP_PRIM_LSB];
            line_fill_q <= wbyte[SDP_LINE_FILL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            curve_fill_q <= 1'b0;
            curve_shape_q <= SDP_SHAPE_ELLIPSE;
            curve_quad_q <= SDP_QUAD_BL;
        end
        else if (curve_wr)
        begin
            curve_fill_q <= wbyte[SDP_CURVE_FILL_BIT];
            curve_shape_q <= sdp_shape_t'(wbyte[SDP_SHAPE_MSB:SDP_SHAPE_LSB]);
            curve_quad_q <= sdp_quad_t'(wbyte[SDP_QUAD_MSB:SDP_QUAD_LSB]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            red_q <= SDP_COLOUR_RST;
            green_q <= SDP_COLOUR_RST;
            blue_q <= SDP_COLOUR_RST;
            depth_q <= SDP_DEPTH_16M;
        end
        else if (wr_now)
        begin
            if (idx == SDP_IDX_RED)
            begin
                red_q <= wbyte;
            end
            if (idx == SDP_IDX_GREEN)
            begin
                green_q <= wbyte;
            end
            if (idx == SDP_IDX_BLUE)
            begin
                blue_q <= wbyte;
            end
            if (idx == SDP_IDX_DEPTH)
            begin
                depth_q <= sdp_depth_t'(wbyte[1:0]);
            end
        end
    end

    // Colour handed to the drawing engine keeps only the bits of the depth.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fg_red_q <= SDP_COLOUR_RST;
            fg_green_q <= SDP_COLOUR_RST;
            fg_blue_q <= SDP_COLOUR_RST;
        end
        else
        begin
            fg_red_q <= keep_top(red_q, SDP_RED_KEEP[depth_sel(depth_q)]);
            fg_green_q <= keep_top(green_q, SDP_GREEN_KEEP[depth_sel(depth_q)]);
            fg_blue_q <= keep_top(blue_q, SDP_BLUE_KEEP[depth_sel(depth_q)]);
        end
    end

    // Degenerate triangles: any two equal vertices give a line, all three a dot.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tri_as_line_q <= 1'b0;
            tri_as_dot_q <= 1'b0;
        end
        else
        begin
            tri_as_dot_q <= endpoint1_x == endpoint2_x && endpoint1_y == endpoint2_y
                && endpoint1_x == vertex3_x && endpoint1_y == vertex3_y;
            tri_as_line_q <= ((endpoint1_x == endpoint2_x && endpoint1_y == endpoint2_y)
                || (endpoint1_x == vertex3_x && endpoint1_y == vertex3_y)
                || (endpoint2_x == vertex3_x && endpoint2_y == vertex3_y))
                && !(endpoint1_x == endpoint2_x && endpoint1_y == endpoint2_y
                && endpoint1_x == vertex3_x && endpoint1_y == vertex3_y);
        end
    end

    always_comb
    begin
        rd_d = 8'h00;
        hit_d = 1'b1;
        if (coord_hit)
        begin
            rd_d = coord_hi ? {3'h0, coord_q[coord_slot][SDP_CW-1:8]} : coord_q[coord_slot][7:0];
        end
        else if (idx == SDP_IDX_LINE_CTRL)
        begin
            rd_d = {line_busy_q, 1'b0, line_fill_q, line_prim_q, 1'b0};
        end
        else if (idx == SDP_IDX_CURVE_CTRL)
        begin
            rd_d = {curve_busy_q, curve_fill_q, curve_shape_q, 2'h0, curve_quad_q};
        end
        else if (idx == SDP_IDX_RED)
        begin
            rd_d = red_q;
        end
        else if (idx == SDP_IDX_GREEN)
        begin
            rd_d = green_q;
        end
        else if (idx == SDP_IDX_BLUE)
        begin
            rd_d = blue_q;
        end
        else if (idx == SDP_IDX_DEPTH)
        begin
            rd_d = {6'h00, depth_q};
        end
        else
        begin
            hit_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (access && !pready_q)
        begin
            prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_d};
            pslverr_q <= !hit_d;
        end
        else
        begin
            pslverr_q <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_access_start;
        psel && penable && !pready_q;
    endsequence

    sequence s_write_lo(logic [7:0] r);
        s_access_start ##1 (wr_now && idx == r);
    endsequence

    apb_ready_a: assert property (s_access_start |=> pready_q ##1 !pready_q)
        else $error("Pready did not rise for exactly one cycle.");

    ep2y_lo_a: assert property (s_write_lo(SDP_COORD_LO[SDP_SLOT_EP2Y]) |=>
        endpoint2_y[7:0] == $past(wbyte))
        else $error("Endpoint 2 Y low byte not stored.");

    curve_busy_a: assert property (curve_wr && wbyte[SDP_START_BIT] |=> curve_busy_q)
        else $error("Curve start did not set busy.");

    line_busy_a: assert property (line_wr && wbyte[SDP_START_BIT] |=> line_busy_q ##0 line_start_q)
        else $error("Line start did not set busy.");

    ctrl_reserved_a: assert property ((s_access_start ##0 (!pwrite && idx == SDP_IDX_CURVE_CTRL))
        |=> prdata_q[3:2] == 2'h0 && prdata_q[7] == $past(curve_busy_q))
        else $error("Curve control reserved bits not zero.");

    shape_sel_a: assert property (curve_wr |=> curve_shape_q == $past(wbyte[5:4]))
        else $error("Shape select not taken from bits 5:4.");

    red_depth_a: assert property (depth_q == SDP_DEPTH_256 |=> fg_red_q[4:0] == 5'h00)
        else $error("Red not cut to three bits at 256 colours.");

    green_depth_a: assert property (depth_q == SDP_DEPTH_65K |=> fg_green_q[1:0] == 2'h0)
        else $error("Green not cut to six bits at 65K colours.");

    tri_dot_a: assert property ((endpoint1_x == endpoint2_x && endpoint2_x == vertex3_x
        && endpoint1_y == endpoint2_y && endpoint2_y == vertex3_y) |=> tri_as_dot_q && !tri_as_line_q)
        else $error("Coincident vertices not flagged as dot.");
endmodule

`default_nettype wire

// ### verification/sdp_rast_model.sv
/*
 * Behavioural rasteriser that answers a start pulse with a done pulse unless a stop or a new start comes first.
 * Assumes one-cycle start and stop pulses on pclk from the register bank.
 */
`timescale 1ns/10ps
`default_nettype none

module sdp_rast_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic stop,
    input wire logic [7:0] lat,
    output logic done
);
    logic [7:0] cnt_q;

    // Pulses done lat cycles after a start; a stop abandons the shape.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 8'h00;
            done <= 1'b0;
        end
        else
        begin
            done <= (cnt_q == 8'h01) && !stop;
            if (start)
                cnt_q <= lat;
            else if (stop || cnt_q == 8'h00)
                cnt_q <= 8'h00;
            else
                cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

`default_nettype wire

// ### verification/shape_draw_param_regs_test.sv
/*
 * Self-checking bench of the shape drawing register bank.
 * Assumes the bank answers APB with pready_q and two rasteriser models finish draws.
 */
`timescale 1ns/10ps
`default_nettype none

module shape_draw_param_regs_test;
    import sdp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] lat = 8'h14;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, line_done, curve_done, l_start, l_stop, l_busy, l_fill;
    logic c_start, c_stop, c_busy, c_fill, tri_line, tri_dot, err_v;
    logic [3:0] l_prim;
    sdp_shape_t c_shape;
    sdp_quad_t c_quad;
    logic [12:0] co [10];
    logic [7:0] red, green, blue, cd;
    logic [31:0] rd_v;
    logic [1:0] ib;
    int error_cnt = 0;
    int n_checks = 0;
    logic [12:0] cval [10] = '{13'h1ABC, 13'h0F0F, 13'h1555, 13'h0AAA, 13'h1001,
                               13'h0FFE, 13'h0040, 13'h1FFF, 13'h0321, 13'h1234};
    logic [7:0] rmask [3] = '{8'hE0, 8'hF8, 8'hFF};
    logic [7:0] gmask [3] = '{8'hE0, 8'hFC, 8'hFF};
    logic [7:0] bmask [3] = '{8'hC0, 8'hF8, 8'hFF};

    always #2.5 pclk = ~pclk;

    sdp_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .line_done(line_done), .curve_done(curve_done), .line_start_q(l_start),
        .line_stop_q(l_stop), .line_busy_q(l_busy), .line_prim_q(l_prim), .line_fill_q(l_fill),
        .curve_start_q(c_start), .curve_stop_q(c_stop), .curve_busy_q(c_busy), .curve_fill_q(c_fill),
        .curve_shape_q(c_shape), .curve_quad_q(c_quad), .endpoint1_x(co[0]), .endpoint1_y(co[1]),
        .endpoint2_x(co[2]), .endpoint2_y(co[3]), .vertex3_x(co[4]), .vertex3_y(co[5]),
        .major_radius(co[6]), .minor_radius(co[7]), .centre_x(co[8]), .centre_y(co[9]),
        .tri_as_line_q(tri_line), .tri_as_dot_q(tri_dot), .fg_red_q(red), .fg_green_q(green),
        .fg_blue_q(blue));

    sdp_rast_model line_rast (.pclk(pclk), .presetn(presetn), .start(l_start), .stop(l_stop),
        .lat(lat), .done(line_done));
    sdp_rast_model curve_rast (.pclk(pclk), .presetn(presetn), .start(c_start), .stop(c_stop),
        .lat(lat), .done(curve_done));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s saw %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    // One APB transfer; holds the request until pready_q is sampled high.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready_q !== 1'b1);
        rd_v = prdata_q;
        err_v = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string msg);
        apb(1'b0, idx, 8'h00);
        chk(rd_v, {24'h000000, exp}, msg);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        tick(3);
        presetn <= 1'b1;
        tick(1);
        for (int i = 0; i < SDP_NCOORD; i++)
        begin
            wr(SDP_COORD_LO[i], cval[i][7:0]);
            wr(SDP_COORD_LO[i] + 8'h01, {3'b111, cval[i][12:8]});
            rdc(SDP_COORD_LO[i] + 8'h01, {3'b000, cval[i][12:8]}, "high byte");
            chk(co[i], cval[i], "coordinate");
        end
        $display("coordinate test done");
        for (int j = 0; j < 6; j++)
        begin
            wr(SDP_COORD_LO[j], 8'h55);
            wr(SDP_COORD_LO[j] + 8'h01, 8'h01);
        end
        tick(2);
        chk({tri_line, tri_dot}, 2'b01, "dot");
        wr(SDP_COORD_LO[SDP_SLOT_V3X], 8'h56);
        tick(2);
        chk({tri_line, tri_dot}, 2'b10, "line");
        wr(SDP_COORD_LO[SDP_SLOT_EP2X], 8'h56);
        tick(2);
        chk({tri_line, tri_dot}, 2'b10, "line late pair");
        $display("triangle test done");
        wr(SDP_IDX_RED, 8'hB7);
        wr(SDP_IDX_GREEN, 8'h6D);
        for (int d = 0; d < 3; d++)
        begin
            wr(SDP_IDX_DEPTH, d[7:0]);
            tick(2);
            chk(red, 8'hB7 & rmask[d], "red");
            chk(green, 8'h6D & gmask[d], "green");
            chk(blue, bmask[d], "blue");
        end
        pstrb <= 4'h0;
        wr(SDP_IDX_RED, 8'h00);
        pstrb <= 4'hF;
        rdc(SDP_IDX_RED, 8'hB7, "red kept");
        $display("colour test done");
        for (int i = 0; i < 4; i++)
        begin
            ib = i[1:0];
            cd = {1'b0, ib[0], ib, 2'b11, ~ib};
            wr(SDP_IDX_CURVE_CTRL, cd);
            chk({c_fill, c_shape, c_quad}, {ib[0], ib, ~ib}, "curve fields");
            rdc(SDP_IDX_CURVE_CTRL, {1'b0, ib[0], ib, 2'b00, ~ib}, "curve ctrl");
        end
        wr(SDP_COORD_LO[SDP_SLOT_MINR], cval[SDP_SLOT_MAJR][7:0]);
        wr(SDP_COORD_LO[SDP_SLOT_MINR] + 8'h01, {3'b000, cval[SDP_SLOT_MAJR][12:8]});
        chk(co[SDP_SLOT_MINR], cval[SDP_SLOT_MAJR], "circle radii");
        wr(SDP_IDX_CURVE_CTRL, 8'h80);
        chk({c_busy, c_start}, 2'b11, "curve busy");
        rdc(SDP_IDX_CURVE_CTRL, 8'h80, "curve drawing");
        for (int k = 0; k < 40 && c_busy === 1'b1; k++)
            tick(1);
        rdc(SDP_IDX_CURVE_CTRL, 8'h00, "curve finished");
        wr(SDP_IDX_CURVE_CTRL, 8'h80);
        wr(SDP_IDX_CURVE_CTRL, 8'h00);
        chk({c_busy, c_stop}, 2'b01, "curve stop");
        $display("curve test done");
        lat <= 8'h01;
        wr(SDP_IDX_LINE_CTRL, 8'hFF);
        chk({l_start, l_fill, l_prim}, 6'h3F, "primitive");
        for (int k = 0; k < 40 && l_busy === 1'b1; k++)
            tick(1);
        rdc(SDP_IDX_LINE_CTRL, 8'h3E, "line finished");
        lat <= 8'h14;
        wr(SDP_IDX_LINE_CTRL, 8'h80);
        chk({l_busy, l_prim}, 5'h10, "line busy");
        rdc(SDP_IDX_LINE_CTRL, 8'h80, "line drawing");
        apb(1'b0, 8'h00, 8'h00);
        chk(err_v, 1'b1, "unmapped error");
        chk(rd_v, 32'h0000_0000, "unmapped data");
        $display("control test done");
        presetn <= 1'b0;
        tick(3);
        presetn <= 1'b1;
        tick(1);
        chk({red, green, c_busy, l_busy, co[1]}, {16'hFFFF, 15'h0000}, "reset ports");
        rdc(SDP_IDX_GREEN, 8'hFF, "green reset");
        rdc(SDP_COORD_LO[SDP_SLOT_EP2X], 8'h00, "coordinate reset");
        $display("reset test done");
        results();
    end

    initial
    begin
        tick(20000);
        error_cnt++;
        $display("wrong value at %0t: run timed out", $time);
        results();
    end
endmodule

`default_nettype wire
